// File: design/rsrb_bank.sv
// register bank with reset handling, status bits and multi-register freeze/abort
`timescale 1ns/1ps
module rsrb_bank (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire rsrb_pkg::rsrb_acc_req_type acc_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  input wire logic [2:0] cfg_pins_in,
  input wire logic [18:0] measured_frequency_in,
  input wire logic [15:0] phase_in,
  input wire logic holdover_ready_in,
  input wire logic [1:0] lock_in,
  input wire logic [1:0] act_in,
  output rsrb_pkg::rsrb_fields_type fields_out,
  output logic [7:0] master_config_out,
  output logic soft_reset_out,
  output logic interrupt_request_pin_out
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic released;
    logic [2:0] cap;
    logic [7:0] master_config_one;
    logic [7:0] ier4;
    rsrb_pkg::rsrb_fields_type fld;
    logic [2:0] seq_grp;
    logic seq_rd;
    logic [2:0] seq_done;
    logic [23:0] seq_buf;
    logic [7:0] rdata;
    logic rvalid;
  } rsrb_bank_state_type;

  localparam rsrb_bank_state_type STATE_RESET = '{
    released: 1'b0,
    cap: '0,
    master_config_one: rsrb_pkg::MASTER_CONFIG_ONE_RESET,
    ier4: rsrb_pkg::IER4_RESET,
    fld: '{
      osc_comp: rsrb_pkg::OSC_COMP_RESET,
      pull_in_limit: rsrb_pkg::PULL_IN_LIMIT_RESET,
      input_divider: rsrb_pkg::INPUT_DIVIDER_RESET,
      measured_frequency_trim: rsrb_pkg::MEASURED_FREQUENCY_TRIM_RESET
    },
    seq_grp: rsrb_pkg::GRP_NONE,
    seq_rd: 1'b0,
    seq_done: '0,
    seq_buf: '0,
    rdata: rsrb_pkg::READ_ZERO,
    rvalid: 1'b0
  };

  rsrb_bank_state_type st;
  rsrb_bank_state_type next_st;

  logic [2:0] cfg_sync;
  logic [1:0] lock_flag;
  logic holdover_flag;
  logic abort_flag;
  logic abort_evt;
  logic wr_latched_status_four;
  logic wr_isr2;
  logic soft_rst;

  // ---------------------------------------------------------------------------
  // address decode helpers
  // ---------------------------------------------------------------------------

  // which multi-register field an address belongs to
  function automatic logic [2:0] grp_of(input logic [8:0] a);
    logic [2:0] g;
    g = rsrb_pkg::GRP_NONE;
    case (a)
      rsrb_pkg::ADDR_MEASURED_FREQUENCY_LOW,
      rsrb_pkg::ADDR_MEASURED_FREQUENCY_MID,
      rsrb_pkg::ADDR_MEASURED_FREQUENCY_TOP: g = rsrb_pkg::GRP_MEASURED_FREQUENCY;
      rsrb_pkg::ADDR_OSCILLATOR_COMP_LOW,
      rsrb_pkg::ADDR_OSCILLATOR_COMP_HIGH: g = rsrb_pkg::GRP_OSC;
      rsrb_pkg::ADDR_PULL_IN_LIMIT_LOW,
      rsrb_pkg::ADDR_PULL_IN_LIMIT_HIGH: g = rsrb_pkg::GRP_LIM;
      rsrb_pkg::ADDR_INPUT_DIVIDER_LOW,
      rsrb_pkg::ADDR_INPUT_DIVIDER_HIGH: g = rsrb_pkg::GRP_DIV;
      rsrb_pkg::ADDR_FREQUENCY_TRIM_LOW,
      rsrb_pkg::ADDR_FREQUENCY_TRIM_HIGH: g = rsrb_pkg::GRP_TRIM;
      rsrb_pkg::ADDR_PHASE_ERROR_LOW,
      rsrb_pkg::ADDR_PHASE_ERROR_HIGH: g = rsrb_pkg::GRP_PHASE;
      default: g = rsrb_pkg::GRP_NONE;
    endcase
    return g;
  endfunction

  // byte position of an address inside its field
  function automatic logic [1:0] byte_of(input logic [8:0] a);
    logic [1:0] b;
    b = rsrb_pkg::BYTE_MID;
    case (a)
      rsrb_pkg::ADDR_MEASURED_FREQUENCY_LOW,
      rsrb_pkg::ADDR_OSCILLATOR_COMP_LOW,
      rsrb_pkg::ADDR_PULL_IN_LIMIT_LOW,
      rsrb_pkg::ADDR_INPUT_DIVIDER_LOW,
      rsrb_pkg::ADDR_FREQUENCY_TRIM_LOW,
      rsrb_pkg::ADDR_PHASE_ERROR_LOW: b = rsrb_pkg::BYTE_LOW;
      rsrb_pkg::ADDR_MEASURED_FREQUENCY_TOP: b = rsrb_pkg::BYTE_TOP;
      default: b = rsrb_pkg::BYTE_MID;
    endcase
    return b;
  endfunction

  // fields that software may only read
  function automatic logic grp_ro(input logic [2:0] g);
    return (g == rsrb_pkg::GRP_MEASURED_FREQUENCY) || (g == rsrb_pkg::GRP_PHASE);
  endfunction

  // ---------------------------------------------------------------------------
  // pin inputs and latched status bits
  // ---------------------------------------------------------------------------

  // configuration straps come from pins, so they are synchronised first
  rsrb_sync2 #(
    .W(rsrb_pkg::CFG_W)
  ) u_cfg_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .pin_in(cfg_pins_in),
    .sync_out(cfg_sync)
  );

  assign soft_rst = st.master_config_one[rsrb_pkg::MASTER_CONFIG_ONE_RST_BIT];
  assign wr_latched_status_four = acc_in.valid && acc_in.write && (acc_in.addr == rsrb_pkg::ADDR_LATCHED_STATUS_FOUR);
  assign wr_isr2 = acc_in.valid && acc_in.write && (acc_in.addr == rsrb_pkg::ADDR_INPUT_STATUS_TWO);

  // holdover ready latches on its rising edge, cleared by writing one
  rsrb_latch #(
    .EDGE_MODE(rsrb_pkg::EDGE_RISE),
    .CLR_VAL(1'b1)
  ) u_holdover_latch (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .srst_in(soft_rst),
    .sig_in(holdover_ready_in),
    .set_in(1'b0),
    .wr_in(wr_latched_status_four),
    .wbit_in(acc_in.wdata[rsrb_pkg::LATCHED_STATUS_FOUR_HOLDOVER_BIT]),
    .flag_out(holdover_flag)
  );

  // multireg_access_aborted is set by the sequence tracker, cleared by writing one
  rsrb_latch #(
    .EDGE_MODE(rsrb_pkg::EDGE_NONE),
    .CLR_VAL(1'b1)
  ) u_abort_latch (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .srst_in(soft_rst),
    .sig_in(1'b0),
    .set_in(abort_evt),
    .wr_in(wr_latched_status_four),
    .wbit_in(acc_in.wdata[rsrb_pkg::LATCHED_STATUS_FOUR_ABORT_BIT]),
    .flag_out(abort_flag)
  );

  // input_lock_latch bits clear on a written zero and feed no interrupt
  rsrb_latch #(
    .EDGE_MODE(rsrb_pkg::EDGE_RISE),
    .CLR_VAL(1'b0)
  ) u_lock_lo_latch (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .srst_in(soft_rst),
    .sig_in(lock_in[0]),
    .set_in(1'b0),
    .wr_in(wr_isr2),
    .wbit_in(acc_in.wdata[rsrb_pkg::INPUT_LOCK_LATCH_LO_BIT]),
    .flag_out(lock_flag[0])
  );

  rsrb_latch #(
    .EDGE_MODE(rsrb_pkg::EDGE_RISE),
    .CLR_VAL(1'b0)
  ) u_lock_hi_latch (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .srst_in(soft_rst),
    .sig_in(lock_in[1]),
    .set_in(1'b0),
    .wr_in(wr_isr2),
    .wbit_in(acc_in.wdata[rsrb_pkg::INPUT_LOCK_LATCH_HI_BIT]),
    .flag_out(lock_flag[1])
  );

  // ---------------------------------------------------------------------------
  // access handling
  // ---------------------------------------------------------------------------

  // one access per valid cycle; the read answer is registered for the next cycle
  always_comb
  begin
    logic [2:0] g;
    logic [1:0] bi;
    logic [4:0] bpos;
    logic [2:0] need;
    logic [23:0] live;
    logic [23:0] src;
    logic [7:0] rd_byte;
    logic fresh;
    logic keep_rst;
    g = rsrb_pkg::GRP_NONE;
    bi = byte_of(acc_in.addr);
    bpos = {1'b0, bi, 2'b00} << 1;
    need = rsrb_pkg::NEED_TWO;
    live = '0;
    src = '0;
    rd_byte = rsrb_pkg::READ_ZERO;
    fresh = 1'b0;
    keep_rst = 1'b0;
    abort_evt = 1'b0;
    next_st = st;
    next_st.rvalid = 1'b0;

    // straps are caught once, in the first cycle after the pin reset lets go
    if (!st.released)
    begin
      next_st.released = 1'b1;
      next_st.cap = cfg_sync;
      next_st.master_config_one[rsrb_pkg::MASTER_CONFIG_ONE_T0_LSB +: rsrb_pkg::CFG_W] = cfg_sync;
    end

    // a write to a read-only field is no part of any sequence; it only ends one that is running
    g = grp_of(acc_in.addr);
    if (acc_in.write && grp_ro(g))
    begin
      g = rsrb_pkg::GRP_NONE;
    end
    if (g == rsrb_pkg::GRP_MEASURED_FREQUENCY)
    begin
      need = rsrb_pkg::NEED_THREE;
    end

    // live value of the addressed field, as the sequence would snapshot it
    case (g)
      rsrb_pkg::GRP_MEASURED_FREQUENCY: live = {5'h00, measured_frequency_in};
      rsrb_pkg::GRP_PHASE: live = {8'h00, phase_in};
      rsrb_pkg::GRP_OSC: live = {8'h00, st.fld.osc_comp};
      rsrb_pkg::GRP_LIM: live = {14'h0000, st.fld.pull_in_limit};
      rsrb_pkg::GRP_DIV: live = {8'h00, st.fld.input_divider};
      rsrb_pkg::GRP_TRIM: live = {8'h00, st.fld.measured_frequency_trim};
      default: live = '0;
    endcase

    if (acc_in.valid)
    begin
      // any access outside the running sequence, or a repeat of a byte, ends it
      if ((st.seq_grp != rsrb_pkg::GRP_NONE) &&
          ((g != st.seq_grp) || (acc_in.write == st.seq_rd) || st.seq_done[bi]))
      begin
        abort_evt = 1'b1;
        next_st.seq_grp = rsrb_pkg::GRP_NONE;
        next_st.seq_done = '0;
      end

      if (g != rsrb_pkg::GRP_NONE)
      begin
        fresh = (next_st.seq_grp == rsrb_pkg::GRP_NONE);
        if (fresh)
        begin
          next_st.seq_grp = g;
          next_st.seq_rd = ~acc_in.write;
          next_st.seq_done = '0;
          next_st.seq_buf = acc_in.write ? '0 : live;
        end
        src = fresh ? live : st.seq_buf;
        next_st.seq_done[bi] = 1'b1;
        if (acc_in.write)
        begin
          next_st.seq_buf[bpos +: 8] = acc_in.wdata;
        end
        else
        begin
          rd_byte = src[bpos +: 8];
        end
        // the last outstanding byte commits a write or releases the freeze
        if ((next_st.seq_done & need) == need)
        begin
          if (acc_in.write)
          begin
            case (g)
              rsrb_pkg::GRP_OSC: next_st.fld.osc_comp = next_st.seq_buf[15:0];
              rsrb_pkg::GRP_LIM: next_st.fld.pull_in_limit = next_st.seq_buf[9:0];
              rsrb_pkg::GRP_DIV: next_st.fld.input_divider = next_st.seq_buf[15:0];
              rsrb_pkg::GRP_TRIM: next_st.fld.measured_frequency_trim = next_st.seq_buf[15:0];
              default: next_st.fld = st.fld;
            endcase
          end
          next_st.seq_grp = rsrb_pkg::GRP_NONE;
          next_st.seq_done = '0;
        end
      end
      else if (acc_in.write)
      begin
        // single registers; read-only places and unmapped addresses take no effect
        case (acc_in.addr)
          rsrb_pkg::ADDR_MASTER_CONFIG_ONE: next_st.master_config_one = acc_in.wdata & rsrb_pkg::MASTER_CONFIG_ONE_WMASK;
          rsrb_pkg::ADDR_LATCHED_ENABLE_FOUR: next_st.ier4 = acc_in.wdata & rsrb_pkg::IER4_WMASK;
          default: next_st.ier4 = next_st.ier4;
        endcase
      end
      else
      begin
        // reserved bits and unmapped addresses read as zero
        case (acc_in.addr)
          rsrb_pkg::ADDR_MASTER_CONFIG_ONE: rd_byte = st.master_config_one;
          rsrb_pkg::ADDR_LATCHED_ENABLE_FOUR: rd_byte = st.ier4;
          rsrb_pkg::ADDR_LATCHED_STATUS_FOUR:
          begin
            rd_byte[rsrb_pkg::LATCHED_STATUS_FOUR_HOLDOVER_BIT] = holdover_flag;
            rd_byte[rsrb_pkg::LATCHED_STATUS_FOUR_ABORT_BIT] = abort_flag;
          end
          rsrb_pkg::ADDR_VALID_STATUS_TWO:
          begin
            rd_byte[rsrb_pkg::VALSR2_HOLDOVER_BIT] = holdover_ready_in;
          end
          rsrb_pkg::ADDR_INPUT_STATUS_TWO:
          begin
            rd_byte[rsrb_pkg::INPUT_LOCK_LATCH_LO_BIT] = lock_flag[0];
            rd_byte[rsrb_pkg::ISR_ACT_LO_BIT] = act_in[0];
            rd_byte[rsrb_pkg::INPUT_LOCK_LATCH_HI_BIT] = lock_flag[1];
            rd_byte[rsrb_pkg::ISR_ACT_HI_BIT] = act_in[1];
          end
          default: rd_byte = rsrb_pkg::READ_ZERO;
        endcase
      end

      if (!acc_in.write)
      begin
        next_st.rdata = rd_byte;
        next_st.rvalid = 1'b1;
      end
    end

    // software reset holds everything but the access port, its own bit and the captured straps at default
    if (soft_rst)
    begin
      keep_rst = next_st.master_config_one[rsrb_pkg::MASTER_CONFIG_ONE_RST_BIT];
      next_st.master_config_one = rsrb_pkg::MASTER_CONFIG_ONE_RESET;
      next_st.master_config_one[rsrb_pkg::MASTER_CONFIG_ONE_T0_LSB +: rsrb_pkg::CFG_W] = st.cap;
      next_st.master_config_one[rsrb_pkg::MASTER_CONFIG_ONE_RST_BIT] = keep_rst;
      next_st.ier4 = STATE_RESET.ier4;
      next_st.fld = STATE_RESET.fld;
      next_st.seq_grp = rsrb_pkg::GRP_NONE;
      next_st.seq_done = '0;
    end
  end

  // synchronous pin reset; captured straps are rebuilt at release, not kept
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      st <= STATE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------

  // lock latches are left out of the request on purpose
  assign interrupt_request_pin_out = |({1'b0, holdover_flag, abort_flag, 5'h00} & st.ier4);
  assign rdata_out = st.rdata;
  assign rvalid_out = st.rvalid;
  assign fields_out = st.fld;
  assign master_config_out = st.master_config_one;
  assign soft_reset_out = soft_rst;

endmodule

// File: design/rsrb_latch.sv
// one latched status bit: edge or event set, software clear, set wins over the clear, soft reset clears over both
`timescale 1ns/1ps
module rsrb_latch #(
  parameter logic [1:0] EDGE_MODE = rsrb_pkg::EDGE_RISE,
  parameter logic CLR_VAL = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic srst_in,
  input wire logic sig_in,
  input wire logic set_in,
  input wire logic wr_in,
  input wire logic wbit_in,
  output logic flag_out
);

  typedef struct packed {
    logic armed;
    logic prev;
    logic flag;
  } rsrb_latch_state_type;

  rsrb_latch_state_type st;
  rsrb_latch_state_type next_st;
  logic hit;

  // the first cycle after reset only samples, so a level already high is no edge
  always_comb
  begin
    next_st = st;
    hit = set_in;
    if (st.armed)
    begin
      hit = hit | (EDGE_MODE[0] & sig_in & ~st.prev) | (EDGE_MODE[1] & ~sig_in & st.prev);
    end
    next_st.prev = sig_in;
    next_st.armed = 1'b1;
    if (wr_in && (wbit_in == CLR_VAL))
    begin
      next_st.flag = 1'b0;
    end
    if (hit)
    begin
      next_st.flag = 1'b1; // set beats a software clear in the same cycle
    end
    if (srst_in)
    begin
      next_st.flag = 1'b0;
    end
  end

  // registered copy of the state
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign flag_out = st.flag;

endmodule

// File: design/rsrb_pkg.sv
// shared constants, register map and carrier types of the reset and register bank
package rsrb_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int CFG_W = 3;
  localparam int MEASURED_FREQUENCY_W = 19;
  localparam int LIM_W = 10;
  localparam int WORD_W = 16;
  localparam int BUF_W = 24;
  localparam int LOCK_N = 2;

  // ---------------------------------------------------------------------------
  // register offsets (byte-wide registers, 000h to 1ffh)
  // ---------------------------------------------------------------------------
  localparam logic [8:0] ADDR_MEASURED_FREQUENCY_TOP = 9'h007;
  localparam logic [8:0] ADDR_MEASURED_FREQUENCY_LOW = 9'h00c;
  localparam logic [8:0] ADDR_MEASURED_FREQUENCY_MID = 9'h00d;
  localparam logic [8:0] ADDR_VALID_STATUS_TWO = 9'h00f;
  localparam logic [8:0] ADDR_INPUT_STATUS_TWO = 9'h011;
  localparam logic [8:0] ADDR_LATCHED_STATUS_FOUR = 9'h017;
  localparam logic [8:0] ADDR_MASTER_CONFIG_ONE = 9'h032;
  localparam logic [8:0] ADDR_OSCILLATOR_COMP_LOW = 9'h03c;
  localparam logic [8:0] ADDR_OSCILLATOR_COMP_HIGH = 9'h03d;
  localparam logic [8:0] ADDR_PULL_IN_LIMIT_LOW = 9'h041;
  localparam logic [8:0] ADDR_PULL_IN_LIMIT_HIGH = 9'h042;
  localparam logic [8:0] ADDR_INPUT_DIVIDER_LOW = 9'h046;
  localparam logic [8:0] ADDR_INPUT_DIVIDER_HIGH = 9'h047;
  localparam logic [8:0] ADDR_LATCHED_ENABLE_FOUR = 9'h048;
  localparam logic [8:0] ADDR_FREQUENCY_TRIM_LOW = 9'h070;
  localparam logic [8:0] ADDR_FREQUENCY_TRIM_HIGH = 9'h071;
  localparam logic [8:0] ADDR_PHASE_ERROR_LOW = 9'h077;
  localparam logic [8:0] ADDR_PHASE_ERROR_HIGH = 9'h078;

  // ---------------------------------------------------------------------------
  // field positions and write masks
  // ---------------------------------------------------------------------------
  localparam int MASTER_CONFIG_ONE_RST_BIT = 7;
  localparam int MASTER_CONFIG_ONE_T0_LSB = 0;
  localparam logic [7:0] MASTER_CONFIG_ONE_WMASK = 8'hb7;
  localparam int LATCHED_STATUS_FOUR_HOLDOVER_BIT = 6;
  localparam int LATCHED_STATUS_FOUR_ABORT_BIT = 5;
  localparam logic [7:0] IER4_WMASK = 8'h60;
  localparam int VALSR2_HOLDOVER_BIT = 6;
  localparam int INPUT_LOCK_LATCH_LO_BIT = 0;
  localparam int ISR_ACT_LO_BIT = 1;
  localparam int INPUT_LOCK_LATCH_HI_BIT = 4;
  localparam int ISR_ACT_HI_BIT = 5;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MASTER_CONFIG_ONE_RESET = 8'h00;
  localparam logic [7:0] IER4_RESET = 8'h00;
  localparam logic [15:0] OSC_COMP_RESET = 16'h0000;
  localparam logic [9:0] PULL_IN_LIMIT_RESET = 10'h000;
  localparam logic [15:0] INPUT_DIVIDER_RESET = 16'h0000;
  localparam logic [15:0] MEASURED_FREQUENCY_TRIM_RESET = 16'h0000;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ---------------------------------------------------------------------------
  // multi-register field groups and their byte masks
  // ---------------------------------------------------------------------------
  localparam logic [2:0] GRP_NONE = 3'h0;
  localparam logic [2:0] GRP_MEASURED_FREQUENCY = 3'h1;
  localparam logic [2:0] GRP_OSC = 3'h2;
  localparam logic [2:0] GRP_LIM = 3'h3;
  localparam logic [2:0] GRP_DIV = 3'h4;
  localparam logic [2:0] GRP_TRIM = 3'h5;
  localparam logic [2:0] GRP_PHASE = 3'h6;
  localparam logic [2:0] NEED_TWO = 3'h3;
  localparam logic [2:0] NEED_THREE = 3'h7;
  localparam logic [1:0] BYTE_LOW = 2'h0;
  localparam logic [1:0] BYTE_MID = 2'h1;
  localparam logic [1:0] BYTE_TOP = 2'h2;

  // ---------------------------------------------------------------------------
  // edge selection of a latched status bit
  // ---------------------------------------------------------------------------
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [8:0] addr;
    logic [7:0] wdata;
  } rsrb_acc_req_type;

  typedef struct packed {
    logic [15:0] osc_comp;
    logic [9:0] pull_in_limit;
    logic [15:0] input_divider;
    logic [15:0] measured_frequency_trim;
  } rsrb_fields_type;

endpackage

// File: design/rsrb_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rsrb_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rsrb_sync_state_type;

  rsrb_sync_state_type st;
  rsrb_sync_state_type next_st;

  // first stage feeds only the second stage
  always_comb
  begin
    next_st = st;
    next_st.meta = pin_in;
    next_st.stable = st.meta;
  end

  // registered copy of the state; it keeps shifting while reset is held, so straps
  // are already through both stages when the bank captures them at release
  always_ff @(posedge clk_sys_in)
  begin
    st <= next_st;
  end

  assign sync_out = st.stable;

endmodule

// File: verification/rsrb_bank_bench.sv
// self-checking bench of the register bank
`timescale 1ns/1ps
module rsrb_bank_bench;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] cfg_pins_in = 3'h5;
  logic [18:0] measured_frequency_in = 19'h5a5a5;
  logic [15:0] phase_in = 16'h1234;
  logic holdover_ready_in = 1'b0;
  logic [1:0] lock_in = 2'h0;
  logic [1:0] act_in = 2'h0;
  rsrb_pkg::rsrb_acc_req_type acc_in;
  rsrb_pkg::rsrb_fields_type fields_out;
  logic [7:0] rdata_out;
  logic [7:0] master_config_out;
  logic [7:0] got;
  logic rvalid_out;
  logic soft_reset_out;
  logic interrupt_request_pin_out;
  logic ok;
  int miscompares = 0;
  int n_tests = 0;
  // rows: low address, high address, data written, read-back expected
  logic [49:0] rows [3] = '{{9'h03c, 9'h03d, 16'ha55a, 16'ha55a},
    {9'h046, 9'h047, 16'h1234, 16'h1234}, {9'h070, 9'h071, 16'hbeef, 16'hbeef}};
  rsrb_bank dut (.*);
  rsrb_host h (.clk_sys_in(clk_sys_in), .rvalid_in(rvalid_out), .rdata_in(rdata_out),
    .acc_out(acc_in));
  always #10 clk_sys_in = ~clk_sys_in;
  // --------------------
  // checking tasks
  // --------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rc(input logic [8:0] a, input logic [7:0] exp);
    h.rd(a, got, ok);
    chk("rvalid", 16'(ok), 16'h0001);
    chk("rdata", 16'(got), 16'(exp));
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial
  begin
    #2000000;
    miscompares++;
    end_of_test();
  end
  // main sequence: straps and an unmapped address, then the table, then the awkward cases
  initial
  begin
    repeat (12) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    h.settle();
    chk("straps", 16'(master_config_out), 16'h0005);
    rc(9'h03d, 8'h00);
    h.wr(9'h1ff, 8'h00);
    rc(9'h1ff, 8'h00);
    foreach (rows[i])
    begin
      h.wr(rows[i][40:32], rows[i][31:24]);
      h.wr(rows[i][49:41], rows[i][23:16]);
      rc(rows[i][49:41], rows[i][7:0]);
      rc(rows[i][40:32], rows[i][15:8]);
    end
    h.wr(9'h00c, 8'hff);
    rc(9'h00c, 8'ha5);
    measured_frequency_in = 19'h00000;
    rc(9'h00d, 8'ha5);
    rc(9'h007, 8'h05);
    h.wr(9'h03c, 8'h11);
    rc(9'h00f, 8'h00);
    h.wr(9'h03d, 8'h22);
    rc(9'h017, 8'h20);
    chk("osc", fields_out.osc_comp, 16'ha55a);
    h.wr(9'h017, 8'h00);
    rc(9'h017, 8'h20);
    h.wr(9'h017, 8'h20);
    rc(9'h017, 8'h00);
    holdover_ready_in = 1'b1;
    rc(9'h00f, 8'h40);
    rc(9'h017, 8'h40);
    chk("irq off", 16'(interrupt_request_pin_out), 16'h0000);
    h.wr(9'h048, 8'h40);
    repeat (2) @(posedge clk_sys_in);
    chk("irq on", 16'(interrupt_request_pin_out), 16'h0001);
    h.wr(9'h017, 8'h40);
    rc(9'h017, 8'h00);
    chk("irq clr", 16'(interrupt_request_pin_out), 16'h0000);
    lock_in = 2'h1;
    act_in = 2'h2;
    rc(9'h011, 8'h21);
    chk("irq lock", 16'(interrupt_request_pin_out), 16'h0000);
    h.wr(9'h011, 8'h01);
    rc(9'h011, 8'h21);
    h.wr(9'h011, 8'h00);
    rc(9'h011, 8'h20);
    cfg_pins_in = 3'h2;
    h.wr(9'h032, 8'h80);
    rc(9'h03c, 8'h00);
    chk("soft cfg", 16'(master_config_out), 16'h0085);
    h.wr(9'h032, 8'h05);
    h.settle();
    rc(9'h048, 8'h00);
    #1 rst_n_in = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    h.settle();
    chk("pin cfg", 16'(master_config_out), 16'h0002);
    rc(9'h011, 8'h20);
    end_of_test();
  end
endmodule

// File: verification/rsrb_bank_properties.sv
// port-level assertions of the register bank
`timescale 1ns/1ps
module rsrb_bank_check (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire rsrb_pkg::rsrb_acc_req_type acc_in,
  input wire logic rvalid_out,
  input wire rsrb_pkg::rsrb_fields_type fields_out,
  input wire logic [7:0] master_config_out,
  input wire logic soft_reset_out,
  input wire logic interrupt_request_pin_out
);
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // oscillator byte writes; the host spaces accesses two cycles apart
  sequence s_lo; acc_in.valid && acc_in.write && acc_in.addr == 9'h03c; endsequence
  sequence s_hi; acc_in.valid && acc_in.write && acc_in.addr == 9'h03d; endsequence
  sequence s_rd; acc_in.valid && !acc_in.write; endsequence
  property p_rd; s_rd |=> rvalid_out; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_ro; acc_in.valid && acc_in.write && acc_in.addr == 9'h00c |=>
    $stable(fields_out); endproperty
  a_ro: assert property (p_ro) else $error("read-only write took effect");
  property p_one; s_hi |=> $stable(fields_out.osc_comp); endproperty
  a_one: assert property (p_one) else $error("partial field update");
  property p_cmt; s_hi ##2 s_lo |=>
    fields_out.osc_comp == {$past(acc_in.wdata, 3), $past(acc_in.wdata)}; endproperty
  a_cmt: assert property (p_cmt) else $error("field not committed");
  property p_abt; s_lo ##2 s_rd ##2 s_hi |=> $stable(fields_out.osc_comp); endproperty
  a_abt: assert property (p_abt) else $error("aborted write landed");
  property p_sf; soft_reset_out |=> fields_out == '0; endproperty
  a_sf: assert property (p_sf) else $error("fields kept in soft reset");
  property p_cfg; soft_reset_out && $past(soft_reset_out, 2) |->
    $stable(master_config_out[2:0]); endproperty
  a_cfg: assert property (p_cfg) else $error("straps resampled");
  property p_irq; soft_reset_out |=> !interrupt_request_pin_out; endproperty
  a_irq: assert property (p_irq) else $error("request in soft reset");
endmodule
bind rsrb_bank rsrb_bank_check chk (.*);

// File: verification/rsrb_host.sv
// host model: byte accesses to the bank and post-reset waits
`timescale 1ns/1ps
module rsrb_host (
  input wire logic clk_sys_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output rsrb_pkg::rsrb_acc_req_type acc_out
);
  // --------------------
  // access tasks
  // --------------------
  initial acc_out = '0;
  // held over the taking edge; released fields go inverted so stale values never match
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1 acc_out = '{1'b1, w, a, d};
    @(posedge clk_sys_in);
    #1 acc_out = '{1'b0, ~w, ~a, ~d};
  endtask
  // callers write zero to reserved places and writable fields whole, except one oscillator write split by a read
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  // answer is fixed at one cycle, so it is taken right after the taking edge
  task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic ok);
    acc(1'b0, a, 8'h00);
    ok = rvalid_in;
    d = rdata_in;
  endtask
  // initialisation waits out the settling time after any reset
  task automatic settle();
    repeat (5000) @(posedge clk_sys_in);
  endtask
endmodule
